/* File: verilog/secgc_ctrl.sv */
// supply enable, default-supply and input-driven voltage control for four rails, pull-down for the two linreg rails
`timescale 1ns/1ns
module secgc_ctrl
    import secgc_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // register port from the two-wire interface logic
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wr_data,
    output logic      [DATA_W-1:0] reg_rd_data,
    output logic                   reg_rd_valid,
    // general purpose input pins and their polarity
    input  wire logic              input_one,
    input  wire logic              input_two,
    input  wire logic              input_three,
    input  wire logic [INPUTS-1:0] input_active_low,
    // per-rail voltage pick bits from the voltage-control register
    input  wire logic [RAILS-1:0]  volt_pick_b,
    // rail controls toward the sequencer and regulators
    output logic      [RAILS-1:0]  rail_on,
    output logic      [RAILS-1:0]  rail_default_supply,
    output logic      [RAILS-1:0]  rail_setting_b,
    output logic      [1:0]        linreg_pulldown_on
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [INPUTS-1:0] pin_raw;
    logic [INPUTS-1:0] sync1_reg;
    logic [INPUTS-1:0] sync2_reg;
    logic [INPUTS-1:0] act_now;
    logic [INPUTS-1:0] act_prev_reg;
    logic [INPUTS-1:0] act_rise;
    logic [INPUTS-1:0] act_fall;

    assign pin_raw = {input_three, input_two, input_one};

    // first stage feeds only the second, nothing else looks at it
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg    <= '0;
            sync2_reg    <= '0;
            act_prev_reg <= '0;
        end else begin
            sync1_reg    <= pin_raw;
            sync2_reg    <= sync1_reg;
            act_prev_reg <= act_now;
        end
    end

    // polarity applied after the synchroniser; changing it can fake one edge
    assign act_now  = sync2_reg ^ input_active_low;
    assign act_rise = act_now & ~act_prev_reg;
    assign act_fall = ~act_now & act_prev_reg;

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]       ctrl_reg  [RAILS];
    logic [7:0]       ctrl_next [RAILS];
    logic [RAILS-1:0] hit;
    logic [RAILS-1:0] en_set;
    logic [RAILS-1:0] en_clr;
    logic [RAILS-1:0] def_next;
    logic [7:0]       rd_mux;

    genvar gi;
    generate
        for (gi = 0; gi < RAILS; gi++) begin : g_rail
            assign hit[gi] = (reg_addr == RAIL_OFS[gi]);

            // all eight bits stored as written, reserved ones included
            // an input edge in the same cycle as a host write wins on bit 0
            always_comb begin
                ctrl_next[gi] = (reg_wr_en && hit[gi]) ? reg_wr_data : ctrl_reg[gi];
                if (en_set[gi]) begin
                    ctrl_next[gi][ON_POS] = 1'b1;
                end else if (en_clr[gi]) begin
                    ctrl_next[gi][ON_POS] = 1'b0;
                end
            end

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ctrl_reg[gi] <= CTRL_RESET;
                end else begin
                    ctrl_reg[gi] <= ctrl_next[gi];
                end
            end

            assign def_next[gi] = ctrl_next[gi][DEF_POS[gi]];

            secgc_rail u_rail (
                .sys_clk       (sys_clk),
                .rst_n         (rst_n),
                .ctrl          (ctrl_reg[gi]),
                .act_rise      (act_rise),
                .act_fall      (act_fall),
                .volt_pick_b   (volt_pick_b[gi]),
                .en_set        (en_set[gi]),
                .en_clr        (en_clr[gi]),
                .setting_b_reg (rail_setting_b[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // on/off ordering among rails belongs to the sequencer; this block only requests
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rail_on             <= '0;
            rail_default_supply <= '0;
            linreg_pulldown_on  <= '0;
        end else begin
            rail_on             <= {ctrl_next[3][ON_POS], ctrl_next[2][ON_POS],
                                    ctrl_next[1][ON_POS], ctrl_next[0][ON_POS]};
            rail_default_supply <= def_next;
            linreg_pulldown_on  <= {~ctrl_next[3][ON_POS] & ~ctrl_next[3][LIN_PDOFF_POS],
                                    ~ctrl_next[2][ON_POS] & ~ctrl_next[2][LIN_PDOFF_POS]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign rd_mux = hit[0] ? ctrl_reg[0] :
                    hit[1] ? ctrl_reg[1] :
                    hit[2] ? ctrl_reg[2] :
                    hit[3] ? ctrl_reg[3] : RD_UNMAPPED;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rd_data  <= '0;
            reg_rd_valid <= 1'b0;
        end else begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rd_data <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sync_lag_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        act_rise[0] |-> $past(pin_raw[0] ^ input_active_low[0], 2))
        else $error("input edge seen without two-stage lag");
    enable_rise_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_reg[0][ESRC_MSB:ESRC_LSB] == 2'h1) && act_rise[0] |=> rail_on[0])
        else $error("rail not switched on by enable input");
    enable_fall_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_reg[1][ESRC_MSB:ESRC_LSB] == 2'h3) && act_fall[2] |=> !rail_on[1])
        else $error("rail not switched off by enable input");
    seq_src_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_reg[2][ESRC_MSB:ESRC_LSB] == SRC_SEQUENCER) && !reg_wr_en
        |=> rail_on[2] == $past(ctrl_reg[2][ON_POS]))
        else $error("sequencer-controlled rail changed without a write");
    buck_write_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr_en && hit[1] && (reg_wr_data[ESRC_MSB:ESRC_LSB] == SRC_SEQUENCER)
        && (ctrl_reg[1][ESRC_MSB:ESRC_LSB] == SRC_SEQUENCER)
        |=> rail_on[1] == $past(reg_wr_data[ON_POS]))
        else $error("buck enable bit write not applied");
    lin_write_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr_en && hit[3] && (ctrl_reg[3][ESRC_MSB:ESRC_LSB] == SRC_SEQUENCER)
        |=> rail_on[3] == $past(reg_wr_data[ON_POS]))
        else $error("regulator enable bit write not applied");
    default_buck_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        rail_default_supply[0] == ctrl_reg[0][BUCK_DEF_POS])
        else $error("buck default supply flag wrong");
    default_lin_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        rail_default_supply[2] == ctrl_reg[2][LIN_DEF_POS])
        else $error("regulator default supply flag wrong");
    pulldown_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        linreg_pulldown_on[0] |-> !rail_on[0 + 2] && !ctrl_reg[2][LIN_PDOFF_POS])
        else $error("pull-down applied while enabled or suppressed");
    readback_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr_en && hit[0] && !reg_rd_en ##1 reg_rd_en && hit[0] && !reg_wr_en
        |=> reg_rd_valid && reg_rd_data[7:1] == $past(reg_wr_data[7:1], 2))
        else $error("register did not read back as written");
    vsrc_decode_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ctrl_reg[3][VSRC_MSB:VSRC_LSB] == 2'h2) && act_rise[1] |=> !rail_setting_b[3])
        else $error("voltage source field decoded wrongly");
endmodule : secgc_ctrl

/* File: shared/secgc_pkg.sv */
// constants for the supply enable / voltage input control block
package secgc_pkg;
    localparam int        RAILS         = 4;
    localparam int        INPUTS        = 3;
    localparam int        ADDR_W        = 10;
    localparam int        DATA_W        = 8;
    // rail order: 0 buck four, 1 buck three, 2 linreg one, 3 linreg two
    localparam logic [9:0] BUCK_FOUR_SUPPLY_CTRL_OFS   = 10'h022;
    localparam logic [9:0] BUCK_THREE_SUPPLY_CTRL_OFS  = 10'h024;
    localparam logic [9:0] LINREG_ONE_SUPPLY_CTRL_OFS  = 10'h026;
    localparam logic [9:0] LINREG_TWO_SUPPLY_CTRL_OFS  = 10'h027;
    localparam logic [9:0] RAIL_OFS [RAILS] = '{BUCK_FOUR_SUPPLY_CTRL_OFS,
        BUCK_THREE_SUPPLY_CTRL_OFS, LINREG_ONE_SUPPLY_CTRL_OFS, LINREG_TWO_SUPPLY_CTRL_OFS};
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] RD_UNMAPPED    = 8'h00;
    // field positions
    localparam int        ON_POS        = 0;
    localparam int        ESRC_LSB      = 1;
    localparam int        ESRC_MSB      = 2;
    localparam int        VSRC_LSB      = 5;
    localparam int        VSRC_MSB      = 6;
    localparam int        BUCK_DEF_POS  = 3;
    localparam int        LIN_DEF_POS   = 7;
    localparam int        LIN_PDOFF_POS = 3;
    localparam int        DEF_POS [RAILS] = '{BUCK_DEF_POS, BUCK_DEF_POS, LIN_DEF_POS, LIN_DEF_POS};
    localparam logic [1:0] SRC_SEQUENCER = 2'h0;
endpackage : secgc_pkg

/* File: verilog/secgc_rail.sv */
// one rail: decodes the input selectors, yields enable set/clear and the A/B pick
`timescale 1ns/1ns
module secgc_rail
    import secgc_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    // control byte and input events
    input  wire logic [7:0]        ctrl,
    input  wire logic [INPUTS-1:0] act_rise,
    input  wire logic [INPUTS-1:0] act_fall,
    input  wire logic              volt_pick_b,
    // results
    output logic                   en_set,
    output logic                   en_clr,
    output logic                   setting_b_reg
);
    logic [1:0] esrc;
    logic [1:0] vsrc;
    logic [1:0] eidx;
    logic [1:0] vidx;
    logic       v_rise;
    logic       v_fall;
    logic       gpi_b_reg;
    logic       gpi_b_next;
    logic       setting_b_next;

    assign esrc   = ctrl[ESRC_MSB:ESRC_LSB];
    assign vsrc   = ctrl[VSRC_MSB:VSRC_LSB];
    assign eidx   = esrc - 2'h1;
    assign vidx   = vsrc - 2'h1;
    assign en_set = (esrc != SRC_SEQUENCER) && act_rise[eidx];
    assign en_clr = (esrc != SRC_SEQUENCER) && act_fall[eidx];
    assign v_rise = (vsrc != SRC_SEQUENCER) && act_rise[vidx];
    assign v_fall = (vsrc != SRC_SEQUENCER) && act_fall[vidx];

    // the input state is kept even under register control so a later switch starts sane
    assign gpi_b_next     = v_rise ? 1'b0 : (v_fall ? 1'b1 : gpi_b_reg);
    assign setting_b_next = (vsrc == SRC_SEQUENCER) ? volt_pick_b : gpi_b_next;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpi_b_reg     <= 1'b0;
            setting_b_reg <= 1'b0;
        end else begin
            gpi_b_reg     <= gpi_b_next;
            setting_b_reg <= setting_b_next;
        end
    end

    rise_to_a_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        v_rise |=> !setting_b_reg) else $error("rise did not select setting A");
    fall_to_b_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        v_fall |=> setting_b_reg) else $error("fall did not select setting B");
    reg_pick_a : assert property (@(posedge sys_clk) disable iff (!rst_n)
        (vsrc == SRC_SEQUENCER) |=> (setting_b_reg == $past(volt_pick_b)))
        else $error("register pick not followed");
endmodule : secgc_rail

/* File: bench/secgc_gpi_host.sv */
// host-side model driving the three general purpose input pins
`timescale 1ns/1ns
module secgc_gpi_host (
    // timing reference
    input  wire logic sys_clk,
    // pins toward the device
    output logic      input_one,
    output logic      input_two,
    output logic      input_three
);
    initial begin
        input_one   = 1'b0;
        input_two   = 1'b0;
        input_three = 1'b0;
    end

    // a level is held four rising edges: the two-stage synchroniser and the output register take three before the outputs show it
    task automatic set_pin(input int idx, input logic lvl);
        @(negedge sys_clk);
        case (idx)
            1: input_one = lvl;
            2: input_two = lvl;
            default: input_three = lvl;
        endcase
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : set_pin
endmodule : secgc_gpi_host

/* File: bench/testbench.sv */
// self-checking bench for the supply enable and voltage input control block
`timescale 1ns/1ns
module testbench
    import secgc_pkg::*;
;
    logic              sys_clk, rst_n, reg_wr_en, reg_rd_en, input_one, input_two, input_three;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wr_data, reg_rd_data;
    logic              reg_rd_valid;
    logic [INPUTS-1:0] input_active_low;
    logic [RAILS-1:0]  volt_pick_b, rail_on, rail_default_supply, rail_setting_b;
    logic [1:0]        linreg_pulldown_on;
    int                errors, cmp_count;

    secgc_gpi_host gpi_host (.sys_clk(sys_clk), .input_one(input_one),
        .input_two(input_two), .input_three(input_three));
    secgc_ctrl uut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .input_one(input_one),
        .input_two(input_two), .input_three(input_three),
        .input_active_low(input_active_low), .volt_pick_b(volt_pick_b), .rail_on(rail_on),
        .rail_default_supply(rail_default_supply), .rail_setting_b(rail_setting_b),
        .linreg_pulldown_on(linreg_pulldown_on));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // all bus tasks start and end just after a falling edge
    task automatic reg_wr(input logic [9:0] a, input logic [7:0] d);
        reg_addr    = a;
        reg_wr_data = d;
        reg_wr_en   = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        // one idle edge so the next call never raises the strobe it just lowered
        @(negedge sys_clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [9:0] a, input logic [7:0] exp);
        reg_addr  = a;
        reg_rd_en = 1'b1;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        check({7'h00, reg_rd_valid}, 8'h01);
        check(reg_rd_data, exp);
        @(negedge sys_clk);
    endtask : reg_rd

    task automatic wr_all(input logic [7:0] d);
        foreach (RAIL_OFS[r]) reg_wr(RAIL_OFS[r], d);
    endtask : wr_all

    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 10'h000;
        reg_wr_data = 8'h00;
        input_active_low = 3'h0;
        volt_pick_b = 4'h0;
        errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        @(negedge sys_clk);
        foreach (RAIL_OFS[r]) reg_rd(RAIL_OFS[r], CTRL_RESET);
        check(linreg_pulldown_on, 8'h03);
        $display("test reset values done");
        wr_all(8'h99);
        check(rail_on, 8'h0f);
        check(rail_default_supply, 8'h0f);
        check(linreg_pulldown_on, 8'h00);
        foreach (RAIL_OFS[r]) reg_rd(RAIL_OFS[r], 8'h99);
        wr_all(8'h98);
        check(rail_on, 8'h00);
        check(linreg_pulldown_on, 8'h00);
        wr_all(8'h91);
        check(rail_default_supply, 8'h0c);
        wr_all(8'h90);
        check(linreg_pulldown_on, 8'h03);
        reg_wr(10'h023, 8'hff);
        reg_rd(10'h023, RD_UNMAPPED);
        check(rail_on, 8'h00);
        // write then read on the very next edge, reserved bit 4 only
        reg_addr    = RAIL_OFS[0];
        reg_wr_data = 8'h10;
        reg_wr_en   = 1'b1;
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        @(negedge sys_clk);
        reg_rd_en = 1'b0;
        check({7'h00, reg_rd_valid}, 8'h01);
        check(reg_rd_data, 8'h10);
        @(negedge sys_clk);
        check(rail_on, 8'h00);
        $display("test register fields done");
        for (int i = 1; i <= 3; i++) begin
            for (int r = 0; r < RAILS; r++) begin
                reg_wr(RAIL_OFS[r], 8'(i << 1));
                gpi_host.set_pin(i % 3 + 1, 1'b1);
                check(rail_on, 8'h00);
                gpi_host.set_pin(i % 3 + 1, 1'b0);
                gpi_host.set_pin(i, 1'b1);
                check(rail_on, 8'(1 << r));
                reg_rd(RAIL_OFS[r], 8'(i << 1) | 8'h01);
                gpi_host.set_pin(i, 1'b0);
                check(rail_on, 8'h00);
                reg_wr(RAIL_OFS[r], 8'h00);
            end
        end
        reg_wr(RAIL_OFS[0], 8'h01);
        gpi_host.set_pin(1, 1'b1);
        gpi_host.set_pin(1, 1'b0);
        check(rail_on, 8'h01);
        reg_wr(RAIL_OFS[0], 8'h00);
        // polarity changed only while no rail listens, since it can form an edge
        gpi_host.set_pin(2, 1'b1);
        input_active_low = 3'h2;
        reg_wr(RAIL_OFS[1], 8'h04);
        gpi_host.set_pin(2, 1'b0);
        check(rail_on, 8'h02);
        gpi_host.set_pin(2, 1'b1);
        check(rail_on, 8'h00);
        reg_wr(RAIL_OFS[1], 8'h00);
        input_active_low = 3'h0;
        gpi_host.set_pin(2, 1'b0);
        $display("test enable inputs done");
        volt_pick_b = 4'hf;
        @(negedge sys_clk);
        @(negedge sys_clk);
        check(rail_setting_b, 8'h0f);
        volt_pick_b = 4'h0;
        @(negedge sys_clk);
        @(negedge sys_clk);
        check(rail_setting_b, 8'h00);
        for (int i = 1; i <= 3; i++) begin
            for (int r = 0; r < RAILS; r++) begin
                reg_wr(RAIL_OFS[r], 8'(i << 5));
                gpi_host.set_pin(i, 1'b1);
                check(rail_setting_b, 8'h00);
                gpi_host.set_pin(i, 1'b0);
                check(rail_setting_b, 8'(1 << r));
                reg_wr(RAIL_OFS[r], 8'h00);
                @(negedge sys_clk);
                check(rail_setting_b, 8'h00);
            end
        end
        $display("test voltage inputs done");
        end_sim();
    end

    // the tests need about 600 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        end_sim();
    end
endmodule : testbench
